// ---- core/byte_fifo.sv ----
// Small byte FIFO with a synchronous flush that empties it while held
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4,
    parameter int CW    = 3
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Control
    input  wire logic          flush,
    input  wire logic          push,
    input  wire logic [W-1:0]  din,
    input  wire logic          pop,
    // State
    output logic      [W-1:0]  dout,
    output logic      [CW-1:0] count,
    output logic               full,
    output logic               empty
);
    // DEPTH must be a power of two: pointers wrap by overflow
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] rd_q;
    logic [PW-1:0] wr_q;
    logic [CW-1:0] cnt_q;
    wire           do_push = push && !full && !flush;
    wire           do_pop  = pop && !empty && !flush;

    assign dout  = mem[rd_q];
    assign count = cnt_q;
    assign full  = (cnt_q == CW'(DEPTH));
    assign empty = (cnt_q == '0);

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_q] <= din;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || flush) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wr_q <= wr_q + 1'b1;
            if (do_pop)  rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule : byte_fifo

// ---- core/link_sync.sv ----
// Two-stage synchroniser for link pins with edge detection after the second stage
module link_sync #(
    parameter int         W       = 3,
    parameter logic [2:0] RST_VAL = 3'h4
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Pins and synchronised view
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    assign level = s2_q;
    assign rise  = s2_q & ~s3_q;
    assign fall  = ~s2_q & s3_q;

    // Only the second stage reads the first
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q <= W'(RST_VAL);
            s2_q <= W'(RST_VAL);
            s3_q <= W'(RST_VAL);
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
endmodule : link_sync

// ---- core/spi_fifo_pkg.sv ----
// Shared constants, register map and types of the SPI FIFO purge/threshold block
package spi_fifo_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 5;
    localparam int DATA_W     = 32;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W      = 3;
    localparam int THR_W      = 2;
    localparam int IRQ_W      = 3;
    localparam int BIT_CNT_W  = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
    localparam logic [ADDR_W-1:0] REG_TXDATA   = 5'h04;
    localparam logic [ADDR_W-1:0] REG_RXDATA   = 5'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 5'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 5'h14;
    localparam logic [ADDR_W-1:0] REG_LEVEL    = 5'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TRIG_BIT    = 0;
    localparam int CTRL_ZFILL_BIT   = 1;
    localparam int CTRL_RXPURGE_BIT = 12;
    localparam int CTRL_TXPURGE_BIT = 13;
    localparam int CTRL_THR_LSB     = 14;
    localparam int IRQ_TX_BIT       = 0;
    localparam int IRQ_RX_BIT       = 1;
    localparam int IRQ_OVF_BIT      = 2;
    localparam int LVL_RX_LSB       = 8;
    localparam int LINK_CS_BIT      = 2;
    localparam int LINK_SCLK_BIT    = 1;
    localparam int LINK_MOSI_BIT    = 0;
    localparam logic [2:0]        LINK_RST  = 3'h4;
    localparam logic [BYTE_W-1:0] FILL_ZERO = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        LINK_IDLE  = 1'b0,
        LINK_SHIFT = 1'b1
    } link_state_e;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_TXDATA) || (a == REG_RXDATA) ||
                    (a == REG_IRQ_STAT) || (a == REG_IRQ_CLR) || (a == REG_IRQ_EN) ||
                    (a == REG_LEVEL);
    endfunction : is_mapped
endpackage : spi_fifo_pkg

// ---- core/spi_fifo_top.sv ----
// SPI slave FIFO controller: purge controls, interrupt threshold, AXI4-Lite registers
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
module spi_fifo_top
    import spi_fifo_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // AXI4-Lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic      [1:0]        s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic      [DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    // SPI link
    input  wire logic              spi_sclk,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   spi_miso_oe,
    // Events
    output logic                   xfer_req,
    output logic                   irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic              aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic              trig_q, zfill_q, tx_purge_q, rx_purge_q;
    logic [THR_W-1:0]  thr_q;
    logic [IRQ_W-1:0]  irq_stat_q, irq_en_q;
    logic              irq_q, xfer_req_q, miso_q, miso_oe_q;
    logic [BYTE_W-1:0] shift_q, rx_shift_q, last_sent_q;
    logic [BIT_CNT_W-1:0] bit_cnt_q;
    logic [CNT_W-1:0]  tx_sent_q;
    link_state_e       link_q;

    // ------------------------------------------------------------
    // FIFOs and link synchroniser
    // ------------------------------------------------------------
    logic [BYTE_W-1:0] tx_dout, rx_dout, rx_byte, load_byte;
    logic [CNT_W-1:0]  tx_count, rx_count;
    logic              tx_full, tx_empty, rx_full, rx_empty;
    logic [2:0]        lnk_lvl, lnk_rise, lnk_fall;
    logic              tx_push, tx_pop, rx_push, rx_pop;
    logic [BYTE_W-1:0] tx_din;

    byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_fifo (
        .clock (clock),
        .rst   (rst),
        .flush (tx_purge_q),
        .push  (tx_push),
        .din   (tx_din),
        .pop   (tx_pop),
        .dout  (tx_dout),
        .count (tx_count),
        .full  (tx_full),
        .empty (tx_empty)
    );

    byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fifo (
        .clock (clock),
        .rst   (rst),
        .flush (rx_purge_q),
        .push  (rx_push),
        .din   (rx_byte),
        .pop   (rx_pop),
        .dout  (rx_dout),
        .count (rx_count),
        .full  (rx_full),
        .empty (rx_empty)
    );

    link_sync #(.W(3), .RST_VAL(LINK_RST)) u_link_sync (
        .clock (clock),
        .rst   (rst),
        .pin   ({spi_cs_n, spi_sclk, spi_mosi}),
        .level (lnk_lvl),
        .rise  (lnk_rise),
        .fall  (lnk_fall)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire              aw_take  = s_axi_awvalid && awready_q;
    wire              w_take   = s_axi_wvalid && wready_q;
    wire              aw_have  = aw_held_q || aw_take;
    wire              w_have   = w_held_q || w_take;
    wire              do_wr    = aw_have && w_have && !bvalid_q;
    wire [ADDR_W-1:0] wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [DATA_W-1:0] wr_data  = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]        wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb;
    wire              aw_next  = aw_have && !do_wr;
    wire              w_next   = w_have && !do_wr;
    wire              b_next   = do_wr || (bvalid_q && !s_axi_bready);
    wire              ar_take  = s_axi_arvalid && arready_q;
    wire              r_next   = ar_take || (rvalid_q && !s_axi_rready);
    wire              wr_ctrl  = do_wr && (wr_addr == REG_CTRL);
    wire              wr_tx    = do_wr && (wr_addr == REG_TXDATA) && wr_strb[0];
    wire              wr_clr   = do_wr && (wr_addr == REG_IRQ_CLR) && wr_strb[0];
    wire              wr_en    = do_wr && (wr_addr == REG_IRQ_EN) && wr_strb[0];
    wire              rd_rx    = ar_take && (s_axi_araddr == REG_RXDATA);

    assign tx_push = wr_tx && !tx_purge_q;
    assign rx_pop  = rd_rx;
    assign tx_din  = wr_data[BYTE_W-1:0];

    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (s_axi_araddr)
            REG_CTRL: begin
                rd_mux[CTRL_TRIG_BIT]                  = trig_q;
                rd_mux[CTRL_ZFILL_BIT]                 = zfill_q;
                rd_mux[CTRL_RXPURGE_BIT]               = rx_purge_q;
                rd_mux[CTRL_TXPURGE_BIT]               = tx_purge_q;
                rd_mux[CTRL_THR_LSB +: THR_W]          = thr_q;
            end
            REG_RXDATA:   rd_mux[BYTE_W-1:0]           = rx_empty ? FILL_ZERO : rx_dout;
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0]            = irq_stat_q;
            REG_IRQ_EN:   rd_mux[IRQ_W-1:0]            = irq_en_q;
            REG_LEVEL: begin
                rd_mux[CNT_W-1:0]                      = tx_count;
                rd_mux[LVL_RX_LSB +: CNT_W]            = rx_count;
            end
            default:      rd_mux                       = '0;
        endcase
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            awready_q <= !aw_next && !b_next;
            wready_q  <= !w_next && !b_next;
            bvalid_q  <= b_next;
            aw_held_q <= aw_next;
            w_held_q  <= w_next;
            if (aw_take) awaddr_q <= s_axi_awaddr;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) bresp_q <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else begin
            arready_q <= !r_next;
            rvalid_q  <= r_next;
            if (ar_take) begin
                rdata_q <= rd_mux;
                rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_q     <= 1'b0;
            zfill_q    <= 1'b0;
            rx_purge_q <= 1'b0;
            tx_purge_q <= 1'b0;
            thr_q      <= '0;
        end else if (wr_ctrl) begin
            if (wr_strb[0]) begin
                trig_q  <= wr_data[CTRL_TRIG_BIT];
                zfill_q <= wr_data[CTRL_ZFILL_BIT];
            end
            if (wr_strb[1]) begin
                rx_purge_q <= wr_data[CTRL_RXPURGE_BIT];
                tx_purge_q <= wr_data[CTRL_TXPURGE_BIT];
                thr_q      <= wr_data[CTRL_THR_LSB +: THR_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Serial link (mode 0 slave)
    // ------------------------------------------------------------
    wire             active    = !lnk_lvl[LINK_CS_BIT];
    wire             cs_start  = lnk_fall[LINK_CS_BIT];
    wire             sck_rise  = lnk_rise[LINK_SCLK_BIT] && active;
    wire             sck_fall  = lnk_fall[LINK_SCLK_BIT] && active;
    wire             byte_done = sck_rise && (bit_cnt_q == '1);
    // Next byte is fetched only when its first bit must go out, on the falling edge
    // after the eighth bit, so a frame that ends after one byte still pops the next byte
    wire             next_load = sck_fall && (bit_cnt_q == '0);
    wire             load_now  = (cs_start && link_q == LINK_IDLE) || next_load;
    wire             tx_avail  = !tx_purge_q && !tx_empty;
    wire [CNT_W-1:0] thr_cnt   = {1'b0, thr_q} + 3'h1;
    wire             tx_hit    = byte_done && ((tx_sent_q + 3'h1) == thr_cnt);
    wire             rx_hit    = !rx_purge_q && (rx_count >= thr_cnt);

    // Previous byte is repeated unless zeros are selected
    assign load_byte = tx_avail ? tx_dout :
                       (zfill_q ? FILL_ZERO : last_sent_q);
    assign tx_pop    = load_now && tx_avail;
    assign rx_byte   = {rx_shift_q[BYTE_W-2:0], lnk_lvl[LINK_MOSI_BIT]};
    assign rx_push   = byte_done && !rx_purge_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            link_q      <= LINK_IDLE;
            bit_cnt_q   <= '0;
            shift_q     <= '0;
            rx_shift_q  <= '0;
            last_sent_q <= '0;
            miso_q      <= 1'b0;
            miso_oe_q   <= 1'b0;
            tx_sent_q   <= '0;
        end else begin
            miso_oe_q <= active;
            case (link_q)
                LINK_IDLE: begin
                    bit_cnt_q <= '0;
                    if (cs_start) begin
                        link_q      <= LINK_SHIFT;
                        miso_q      <= load_byte[BYTE_W-1];
                        shift_q     <= {load_byte[BYTE_W-2:0], 1'b0};
                        last_sent_q <= load_byte;
                    end
                end
                LINK_SHIFT: begin
                    if (!active) begin
                        link_q <= LINK_IDLE;
                    end else begin
                        if (sck_rise) begin
                            bit_cnt_q  <= bit_cnt_q + 1'b1;
                            rx_shift_q <= rx_byte;
                        end
                        if (byte_done) begin
                            tx_sent_q <= tx_hit ? '0 : tx_sent_q + 3'h1;
                        end
                        if (next_load) begin
                            miso_q      <= load_byte[BYTE_W-1];
                            shift_q     <= {load_byte[BYTE_W-2:0], 1'b0};
                            last_sent_q <= load_byte;
                        end else if (sck_fall) begin
                            miso_q  <= shift_q[BYTE_W-1];
                            shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
                        end
                    end
                end
                default: link_q <= LINK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts and transfer trigger
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    always_comb begin
        irq_set              = '0;
        irq_set[IRQ_TX_BIT]  = tx_hit;
        irq_set[IRQ_RX_BIT]  = rx_hit;
        irq_set[IRQ_OVF_BIT] = byte_done && !rx_purge_q && rx_full;
    end

    wire [IRQ_W-1:0] clr_mask = wr_clr ? wr_data[IRQ_W-1:0] : '0;
    wire             start    = (rd_rx && !trig_q) || (tx_push && trig_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
            irq_q      <= 1'b0;
            xfer_req_q <= 1'b0;
        end else begin
            // Set beats a clear landing in the same cycle
            irq_stat_q <= (irq_stat_q & ~clr_mask) | irq_set;
            if (wr_en) irq_en_q <= wr_data[IRQ_W-1:0];
            irq_q      <= |(irq_stat_q & irq_en_q);
            xfer_req_q <= start;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign spi_miso      = miso_q;
    assign spi_miso_oe   = miso_oe_q;
    assign xfer_req      = xfer_req_q;
    assign irq           = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rx_thresh_a: assert property (@(posedge clock) disable iff (rst)
        (!rx_purge_q && rx_count >= ({1'b0, thr_q} + 3'h1)) |=> irq_stat_q[IRQ_RX_BIT])
        else $error("rx threshold reached without rx interrupt");
    tx_purge_a: assert property (@(posedge clock) disable iff (rst)
        tx_purge_q |=> (tx_count == '0))
        else $error("tx FIFO not empty during purge");
    purge_fill_a: assert property (@(posedge clock) disable iff (rst)
        (load_now && tx_purge_q && link_q == LINK_SHIFT) |=>
        (last_sent_q == ($past(zfill_q) ? FILL_ZERO : $past(last_sent_q))))
        else $error("wrong fill byte during tx purge");
    tx_drop_a: assert property (@(posedge clock) disable iff (rst)
        (tx_purge_q && wr_tx) |-> !tx_push)
        else $error("tx write accepted during purge");
    tx_resume_a: assert property (@(posedge clock) disable iff (rst)
        (wr_tx && !tx_purge_q && !tx_full && !tx_pop) |=>
        (tx_count == CNT_W'($past(tx_count) + 3'h1)))
        else $error("tx write lost after purge cleared");
    rx_purge_a: assert property (@(posedge clock) disable iff (rst)
        rx_purge_q |=> (rx_count == '0))
        else $error("rx FIFO not empty during purge");
    rx_noirq_a: assert property (@(posedge clock) disable iff (rst)
        (rx_purge_q && !irq_stat_q[IRQ_RX_BIT]) |=> !irq_stat_q[IRQ_RX_BIT])
        else $error("rx interrupt raised during purge");
    read_start_a: assert property (@(posedge clock) disable iff (rst)
        (rx_purge_q && !trig_q && rd_rx) |=> xfer_req_q ##1 !xfer_req_q)
        else $error("rx read did not start a transfer");
    empty_fill_a: assert property (@(posedge clock) disable iff (rst)
        (cs_start && link_q == LINK_IDLE && tx_empty && zfill_q) |=> (last_sent_q == FILL_ZERO))
        else $error("zero fill not applied on empty tx FIFO");
endmodule : spi_fifo_top

// ---- verif/spi_fifo_flush_irq_threshold_test.sv ----
// Self-checking bench for thresholds, purges and fill bytes of the SPI FIFO block
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module spi_fifo_flush_irq_threshold_test
    import spi_fifo_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, xfer_req, irq;
    logic        awready, wready, bvalid, arready, rvalid, sclk, cs_n, mosi, miso;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  rx_byte;
    int          num_errors = 0, n_tests = 0, cycles = 0, n_req = 0;
    spi_fifo_top dut_u (.clock(clock), .rst(rst), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(), .xfer_req(xfer_req), .irq(irq));
    spi_master_model spi_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    always #25 clock = ~clock;
    // Watchdog; the whole run needs about two thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (xfer_req === 1'b1) n_req++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic frames(input int n);
        repeat (n) spi_u.xfer(8'h3C, rx_byte);
    endtask : frames
    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
    endtask : do_reset
    task automatic test_thresholds();
        for (int t = 0; t < 4; t++) begin
            do_reset();
            wr(REG_CTRL, 32'(t) << CTRL_THR_LSB);
            wr(REG_IRQ_EN, 32'h3);
            frames(t);
            rd(REG_IRQ_STAT);
            `CHK("stat below", 32'h0, d);
            frames(1);
            rd(REG_LEVEL);
            `CHK("rx level", 3'(t + 1), d[10:8]);
            rd(REG_IRQ_STAT);
            `CHK("stat at", 32'h3, d);
            `CHK("irq", 1'b1, irq);
            wr(REG_IRQ_EN, 32'h0);
            wr(REG_IRQ_CLR, 32'h1);
            rd(REG_IRQ_STAT);
            `CHK("stat cleared", 32'h2, d);
            `CHK("irq masked", 1'b0, irq);
        end
        $display("thresholds done");
    endtask : test_thresholds
    task automatic test_tx_purge();
        do_reset();
        wr(REG_TXDATA, 32'hA1);
        wr(REG_TXDATA, 32'hA2);
        wr(REG_CTRL, 32'h2002);
        wr(REG_TXDATA, 32'hA3);
        rd(REG_LEVEL);
        `CHK("tx purged", 3'h0, d[2:0]);
        frames(2);
        `CHK("zero fill", 8'h00, rx_byte);
        wr(REG_CTRL, 32'h0);
        wr(REG_TXDATA, 32'h5A);
        rd(REG_LEVEL);
        `CHK("tx level", 3'h1, d[2:0]);
        frames(3);
        `CHK("repeat fill", 8'h5A, rx_byte);
        wr(REG_CTRL, 32'h2000);
        frames(2);
        `CHK("purge repeat", 8'h5A, rx_byte);
        $display("tx purge done");
    endtask : test_tx_purge
    task automatic test_rx_purge();
        do_reset();
        frames(1);
        wr(REG_CTRL, 32'h1000);
        wr(REG_IRQ_EN, 32'h2);
        rd(REG_LEVEL);
        `CHK("rx purged", 3'h0, d[10:8]);
        wr(REG_IRQ_CLR, 32'h7);
        frames(1);
        rd(REG_IRQ_STAT);
        `CHK("no rx irq", 1'b0, d[IRQ_RX_BIT]);
        n_req = 0;
        rd(REG_RXDATA);
        repeat (2) @(posedge clock);
        `CHK("read trigger", 1, n_req);
        wr(REG_CTRL, 32'h0);
        frames(1);
        rd(REG_RXDATA);
        `CHK("rx byte", 8'h3C, d[7:0]);
        rd(5'h1C);
        `CHK("unmapped", RESP_SLVERR, resp);
        $display("rx purge done");
    endtask : test_rx_purge
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        test_thresholds();
        test_tx_purge();
        test_rx_purge();
        complete_run();
    end
endmodule : spi_fifo_flush_irq_threshold_test

// ---- verif/spi_master_model.sv ----
// Behavioural SPI master, mode 0, MSB first, standing on the link side
module spi_master_model (
    // Link
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Whole bytes only; the clock stands still outside frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        #400;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #200 sclk = 1'b1;
            rx[i] = miso;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        // Idle line shows a changed level so a stale bit cannot pass
        mosi = ~mosi;
        #400;
    endtask : xfer
endmodule : spi_master_model
